//--- hdl/uart_line_modem_status_regs.sv
// Line status, modem status and special-function registers of one UART channel.
// Assumes FIFO, transmitter and receiver report their state as same-clock levels,
// and modem pins arrive asynchronously.
`timescale 1ns/10ps
module uart_line_modem_status_regs
  import uart_status_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_rx_fifo_not_empty,
  input wire logic i_rx_overrun,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_break,
  input wire logic i_tx_holding_empty,
  input wire logic i_tx_shift_empty,
  input wire logic i_rx_fifo_err,
  input wire logic [7:0] i_rx_fifo_count,
  input wire logic [7:0] i_line_status_count,
  input wire logic [7:0] i_tx_fifo_count,
  input wire logic [7:0] i_sample_clock_setting,
  input wire logic i_loopback,
  input wire logic i_aux_output_one,
  input wire logic i_aux_output_two,
  input wire logic i_dtr_ctrl,
  input wire logic i_rts_ctrl,
  input wire logic i_cts_pin,
  input wire logic i_dsr_pin,
  input wire logic i_ri_pin,
  input wire logic i_dcd_pin,
  output logic [7:0] o_reg_rdata,
  output logic o_force_tx,
  output logic o_auto_dsr_dtr,
  output logic o_mode_950,
  output logic o_tx_hold_off
);
  logic [MODEM_PINS-1:0] pins_raw;
  logic [MODEM_PINS-1:0] pins_sync;
  logic [MODEM_PINS-1:0] level_reg;
  logic [MODEM_PINS-1:0] level_next;
  logic [MODEM_PINS-1:0] prev_reg;
  logic [MODEM_PINS-1:0] delta_reg;
  logic [MODEM_PINS-1:0] delta_next;
  logic [MODEM_PINS-1:0] change;
  logic [7:0] line_status_next;
  logic [7:0] modem_status;
  logic [7:0] special_reg;
  logic [7:0] special_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic force_tx_reg;
  logic auto_reg;
  logic mode_950_reg;
  logic hold_off_reg;
  logic hold_off_next;
  logic hit_line;
  logic hit_modem;
  logic hit_special;
  logic hit_count15;
  logic hit_count16;
  logic modem_read;
  logic special_write;
  logic lb_reg;
  logic lb_aux1_reg;
  logic lb_aux2_reg;
  logic lb_dtr_reg;
  logic lb_rts_reg;
  logic line_count_sel;
  logic tx_count_sel;

  assign pins_raw[PIN_CTS] = i_cts_pin;
  assign pins_raw[PIN_DSR] = i_dsr_pin;
  assign pins_raw[PIN_RI] = i_ri_pin;
  assign pins_raw[PIN_DCD] = i_dcd_pin;

  modem_pin_sync #(
    .WIDTH(MODEM_PINS)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_pins(pins_raw),
    .o_pins_sync(pins_sync)
  );

  // Loopback controls are same-clock; registered so a pin swap lands as one clean step
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lb_reg <= 1'b0;
    end
    else
    begin
      lb_reg <= i_loopback;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lb_aux1_reg <= 1'b0;
    end
    else
    begin
      lb_aux1_reg <= i_aux_output_one;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lb_aux2_reg <= 1'b0;
    end
    else
    begin
      lb_aux2_reg <= i_aux_output_two;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lb_dtr_reg <= 1'b0;
    end
    else
    begin
      lb_dtr_reg <= i_dtr_ctrl;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      lb_rts_reg <= 1'b0;
    end
    else
    begin
      lb_rts_reg <= i_rts_ctrl;
    end
  end

  // Loopback feeds the modem controls back in place of the pins
  assign level_next[PIN_CTS] = lb_reg ? lb_rts_reg : pins_sync[PIN_CTS];
  assign level_next[PIN_DSR] = lb_reg ? lb_dtr_reg : pins_sync[PIN_DSR];
  assign level_next[PIN_RI] = lb_reg ? lb_aux1_reg : pins_sync[PIN_RI];
  assign level_next[PIN_DCD] = lb_reg ? lb_aux2_reg : pins_sync[PIN_DCD];

  // Address decode
  assign hit_line = (i_reg_addr == LINE_STATUS_OFFSET);
  assign hit_modem = (i_reg_addr == MODEM_STATUS_OFFSET);
  assign hit_special = (i_reg_addr == SPECIAL_FUNCTION_OFFSET);
  assign hit_count15 = (i_reg_addr == COUNTER_SELECT_OFFSET);
  assign hit_count16 = (i_reg_addr == TX_COUNT_SELECT_OFFSET);
  assign modem_read = i_reg_rd && hit_modem;
  assign special_write = i_reg_wr && hit_special;

  // Counter selectors for the two shared offsets
  assign line_count_sel = special_reg[SF_SEL_LINE_COUNT];
  assign tx_count_sel = special_reg[SF_SEL_TX_COUNT];

  // Change detection on the settled level
  assign change[PIN_CTS] = level_reg[PIN_CTS] ^ prev_reg[PIN_CTS];
  assign change[PIN_DSR] = level_reg[PIN_DSR] ^ prev_reg[PIN_DSR];
  assign change[PIN_RI] = level_reg[PIN_RI] && !prev_reg[PIN_RI];
  assign change[PIN_DCD] = level_reg[PIN_DCD] ^ prev_reg[PIN_DCD];

  // Set beats the read clear, so an edge seen during the read is kept
  assign delta_next = change | (modem_read ? {MODEM_PINS{1'b0}} : delta_reg);

  assign modem_status = {level_reg[PIN_DCD], level_reg[PIN_RI],
                         level_reg[PIN_DSR], level_reg[PIN_CTS], delta_reg};

  assign line_status_next = {i_rx_fifo_err,
                             i_tx_shift_empty,
                             i_tx_holding_empty,
                             i_rx_break,
                             i_rx_frame_err,
                             i_rx_parity_err,
                             i_rx_overrun,
                             i_rx_fifo_not_empty};

  // Reserved bits 2 and 3 are read-only zero; bit 4 stores but does nothing
  assign special_next = special_write ? (i_reg_wdata & SPECIAL_WRITE_MASK) : special_reg;

  // Read data: registered, so it appears one cycle after the read strobe
  assign rdata_next = !i_reg_rd ? rdata_reg :
                      hit_line ? line_status_next :
                      hit_modem ? modem_status :
                      hit_special ? special_reg :
                      hit_count15 ? (line_count_sel ? i_line_status_count
                                     : i_rx_fifo_count) :
                      hit_count16 ? (tx_count_sel ? i_tx_fifo_count
                                     : i_sample_clock_setting) :
                      REG_RESET;

  // Hold-off when auto flow control is on and the far end drops DSR, unless forced
  assign hold_off_next = special_reg[SF_AUTO_DSR_DTR] && !level_reg[PIN_DSR]
                         && !special_reg[SF_FORCE_TX];

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      level_reg <= {MODEM_PINS{1'b0}};
    end
    else
    begin
      level_reg <= level_next;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      prev_reg <= {MODEM_PINS{1'b0}};
    end
    else
    begin
      prev_reg <= level_reg;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      delta_reg <= {MODEM_PINS{1'b0}};
    end
    else
    begin
      delta_reg <= delta_next;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      special_reg <= REG_RESET;
    end
    else
    begin
      special_reg <= special_next;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      rdata_reg <= REG_RESET;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      force_tx_reg <= 1'b0;
    end
    else
    begin
      force_tx_reg <= special_reg[SF_FORCE_TX];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      auto_reg <= 1'b0;
    end
    else
    begin
      auto_reg <= special_reg[SF_AUTO_DSR_DTR];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      mode_950_reg <= 1'b0;
    end
    else
    begin
      mode_950_reg <= special_reg[SF_MODE_950];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      hold_off_reg <= 1'b0;
    end
    else
    begin
      hold_off_reg <= hold_off_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_force_tx = force_tx_reg;
  assign o_auto_dsr_dtr = auto_reg;
  assign o_mode_950 = mode_950_reg;
  assign o_tx_hold_off = hold_off_reg;
endmodule : uart_line_modem_status_regs

//--- hdl/uart_status_pkg.sv
// Package: offsets, field positions and reset values for the channel status registers
// Assumes a byte-wide host register port and an 8-bit register address.
package uart_status_pkg;
  localparam logic [7:0] LINE_STATUS_OFFSET = 8'h05;
  localparam logic [7:0] MODEM_STATUS_OFFSET = 8'h06;
  localparam logic [7:0] SPECIAL_FUNCTION_OFFSET = 8'h07;
  localparam logic [7:0] COUNTER_SELECT_OFFSET = 8'h15;
  localparam logic [7:0] TX_COUNT_SELECT_OFFSET = 8'h16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_WRITE_MASK = 8'hF3;
  localparam int SF_FORCE_TX = 0;
  localparam int SF_AUTO_DSR_DTR = 1;
  localparam int SF_MODE_950 = 5;
  localparam int SF_SEL_LINE_COUNT = 6;
  localparam int SF_SEL_TX_COUNT = 7;
  localparam int PIN_CTS = 0;
  localparam int PIN_DSR = 1;
  localparam int PIN_RI = 2;
  localparam int PIN_DCD = 3;
  localparam int MODEM_PINS = 4;
endpackage : uart_status_pkg

//--- hdl/modem_pin_sync.sv
// Two-stage synchroniser bank for the modem-control input pins.
// Assumes pins are asynchronous to i_sys_clk.
`timescale 1ns/10ps
module modem_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_pins_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge i_sys_clk)
      begin
        if (!i_reset_n)
        begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= i_pins[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign o_pins_sync = sync_reg;
endmodule : modem_pin_sync

//--- testbench/modem_line_partner.sv
// Remote modem model: drives CTS, DSR, RI and DCD toward a target pattern.
// Assumes the bench sets the target; the pins follow after a fixed lag.
`timescale 1ns/10ps
module modem_line_partner #(
  parameter int LAG = 3
) (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_target,
  output logic [3:0] o_pins
);
  logic [3:0] stage_reg [LAG] = '{default: 4'h0};
  // A slow modem settles its lines some cycles after it decides to change them
  always @(posedge i_sys_clk)
  begin
    stage_reg[0] <= i_target;
    for (int i = 1; i < LAG; i++)
      stage_reg[i] <= stage_reg[i-1];
  end
  assign o_pins = stage_reg[LAG-1];
endmodule : modem_line_partner

//--- testbench/uart_line_modem_status_regs_chk.sv
// Checker for read data, counter selection and transmit flow outputs.
// Assumes binding to uart_line_modem_status_regs in one clock domain.
`timescale 1ns/10ps
module uart_line_modem_status_regs_chk
  import uart_status_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_rx_fifo_not_empty,
  input wire logic [7:0] i_line_status_count,
  input wire logic [7:0] i_tx_fifo_count,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_force_tx,
  input wire logic o_auto_dsr_dtr,
  input wire logic o_mode_950,
  input wire logic o_tx_hold_off
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence rd_at(a);
    i_reg_rd && !i_reg_wr && i_reg_addr == a;
  endsequence
  sequence sf_any;
    i_reg_wr && i_reg_addr == SPECIAL_FUNCTION_OFFSET;
  endsequence
  sequence sf_quiet;
    !(i_reg_wr && i_reg_addr == SPECIAL_FUNCTION_OFFSET);
  endsequence
  sequence sf_wr(b);
    sf_any and i_reg_wdata[b];
  endsequence
  property cfg_follows(b, o);
    sf_any |-> ##2 o == $past(i_reg_wdata[b], 2);
  endproperty
  AST_LINE_READY: assert property (rd_at(LINE_STATUS_OFFSET) |=>
    o_reg_rdata[0] == $past(i_rx_fifo_not_empty)) else $error("rx ready bit wrong");
  AST_LINE_SEL: assert property (sf_wr(SF_SEL_LINE_COUNT) ##1 sf_quiet
    ##1 rd_at(COUNTER_SELECT_OFFSET) |=> o_reg_rdata == $past(i_line_status_count))
    else $error("line count not selected");
  AST_TX_SEL: assert property (sf_wr(SF_SEL_TX_COUNT) ##1 sf_quiet
    ##1 rd_at(TX_COUNT_SELECT_OFFSET) |=> o_reg_rdata == $past(i_tx_fifo_count))
    else $error("tx count not selected");
  AST_FORCE: assert property (cfg_follows(SF_FORCE_TX, o_force_tx))
    else $error("force bit not applied");
  AST_AUTO: assert property (cfg_follows(SF_AUTO_DSR_DTR, o_auto_dsr_dtr))
    else $error("auto flow bit not applied");
  AST_MODE: assert property (cfg_follows(SF_MODE_950, o_mode_950))
    else $error("mode bit not applied");
  AST_FORCE_HOLD: assert property (o_force_tx [*2] |-> !o_tx_hold_off)
    else $error("transmit held while forced");
  AST_AUTO_HOLD: assert property (!o_auto_dsr_dtr [*2] |-> !o_tx_hold_off)
    else $error("transmit held with auto flow off");
endmodule : uart_line_modem_status_regs_chk

bind uart_line_modem_status_regs uart_line_modem_status_regs_chk i_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
  .i_rx_fifo_not_empty(i_rx_fifo_not_empty), .i_line_status_count(i_line_status_count),
  .i_tx_fifo_count(i_tx_fifo_count), .o_reg_rdata(o_reg_rdata), .o_force_tx(o_force_tx),
  .o_auto_dsr_dtr(o_auto_dsr_dtr), .o_mode_950(o_mode_950), .o_tx_hold_off(o_tx_hold_off)
);

//--- testbench/uart_line_modem_status_regs_test.sv
// Self-checking bench for the channel status registers.
// Assumes the modem partner model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module uart_line_modem_status_regs_test;
  import uart_status_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd = 1'b0, wr = 1'b0, pend = 1'b0, loopback = 1'b0, aux_one = 1'b0, aux_two = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, line = 8'h00, rdata;
  logic [7:0] cnt [4] = '{default: 8'h00};
  logic [3:0] target = 4'h0, pins;
  logic force_tx, auto_flow, mode_950, hold_off;
  logic [7:0] exp_q [$];
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'hA9F6;
  modem_line_partner #(.LAG(3)) i_partner (.i_sys_clk(sys_clk), .i_target(target), .o_pins(pins));
  uart_line_modem_status_regs i_dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
    .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_rx_fifo_not_empty(line[0]), .i_rx_overrun(line[1]), .i_rx_parity_err(line[2]),
    .i_rx_frame_err(line[3]), .i_rx_break(line[4]), .i_tx_holding_empty(line[5]),
    .i_tx_shift_empty(line[6]), .i_rx_fifo_err(line[7]), .i_rx_fifo_count(cnt[0]),
    .i_line_status_count(cnt[1]), .i_tx_fifo_count(cnt[2]), .i_sample_clock_setting(cnt[3]),
    .i_loopback(loopback), .i_aux_output_one(aux_one), .i_aux_output_two(aux_two),
    .i_dtr_ctrl(1'b0), .i_rts_ctrl(1'b0), .i_cts_pin(pins[PIN_CTS]), .i_dsr_pin(pins[PIN_DSR]),
    .i_ri_pin(pins[PIN_RI]), .i_dcd_pin(pins[PIN_DCD]), .o_reg_rdata(rdata),
    .o_force_tx(force_tx), .o_auto_dsr_dtr(auto_flow), .o_mode_950(mode_950),
    .o_tx_hold_off(hold_off));
  initial
    forever #10 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks made: %0d, mismatches: %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_read
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write
  // Read data lands one edge after the read is taken, so compare on the falling edge
  always @(posedge sys_clk)
    pend <= rd;
  always @(negedge sys_clk)
    if (pend)
      check(rdata, exp_q.pop_front());
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (cnt[i]) cnt[i] <= 8'($random(seed));
    @(posedge sys_clk);
    reg_read(MODEM_STATUS_OFFSET, REG_RESET);
    reg_read(SPECIAL_FUNCTION_OFFSET, REG_RESET);
    reg_read(8'h08, REG_RESET);
    for (int i = 0; i < 8; i++)
    begin
      line <= 8'h01 << i;
      reg_read(LINE_STATUS_OFFSET, 8'h01 << i);
    end
    reg_write(SPECIAL_FUNCTION_OFFSET, 8'hFF);
    reg_read(SPECIAL_FUNCTION_OFFSET, SPECIAL_WRITE_MASK);
    check({5'h00, mode_950, auto_flow, force_tx}, 8'h07);
    for (int s = 0; s < 2; s++)
    begin
      reg_write(SPECIAL_FUNCTION_OFFSET, s ? 8'h00 : 8'hC0);
      reg_read(COUNTER_SELECT_OFFSET, s ? cnt[0] : cnt[1]);
      reg_write(SPECIAL_FUNCTION_OFFSET, s ? 8'h00 : 8'hC0);
      reg_read(TX_COUNT_SELECT_OFFSET, s ? cnt[3] : cnt[2]);
    end
    check({5'h00, mode_950, auto_flow, force_tx}, 8'h00);
    // Hold-off lands on the edge the write task returns on, so look one edge later
    reg_write(SPECIAL_FUNCTION_OFFSET, 8'h02);
    @(posedge sys_clk);
    check({7'h00, hold_off}, 8'h01);
    reg_write(SPECIAL_FUNCTION_OFFSET, 8'h03);
    @(posedge sys_clk);
    check({7'h00, hold_off}, 8'h00);
    target <= 4'hF;
    repeat (10) @(posedge sys_clk);
    reg_read(MODEM_STATUS_OFFSET, 8'hFF);
    reg_read(MODEM_STATUS_OFFSET, 8'hF0);
    target <= 4'h0;
    repeat (10) @(posedge sys_clk);
    reg_read(MODEM_STATUS_OFFSET, 8'h0B);
    // Time the read to sample on the edge that sets the change flag
    target <= 4'h1;
    repeat (6) @(posedge sys_clk);
    reg_read(MODEM_STATUS_OFFSET, 8'h10);
    reg_read(MODEM_STATUS_OFFSET, 8'h11);
    loopback <= 1'b1;
    aux_one <= 1'b1;
    aux_two <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reg_read(MODEM_STATUS_OFFSET, 8'hCD);
    reg_read(MODEM_STATUS_OFFSET, 8'hC0);
    repeat (2) @(posedge sys_clk);
    end_of_test();
  end
endmodule : uart_line_modem_status_regs_test
